// *** logic/fsc_cfg.svh ***
// Fault scan control constants: addresses, fields, resets, timing.
// Assumes inclusion by bare name from the package and the top module.
`ifndef FSC_CFG_SVH
`define FSC_CFG_SVH
`define FSC_ADDR_TIMING 8'h67
`define FSC_ADDR_AVG 8'h68
`define FSC_RST_TIMING 8'hB8
`define FSC_RST_AVG 8'h00
`define FSC_AVG_WMASK 8'hF0
`define FSC_AVG_RSV_MSB 3
`define FSC_AVG_RSV_LSB 0
`define FSC_REP_MSB 7
`define FSC_REP_LSB 6
`define FSC_DBN_MSB 3
`define FSC_DBN_LSB 2
`define FSC_VSH_BIT 1
`define FSC_DBL_BIT 0
`define FSC_AVG_MSB 7
`define FSC_AVG_LSB 6
`define FSC_BLB_BIT 5
`define FSC_OTB_BIT 4
`define FSC_CNT16 5'h10
`define FSC_CNT8 5'h08
`define FSC_CNT4 5'h04
`define FSC_CLK_MHZ 40
`define FSC_PER1_US 1000
`define FSC_PER4_US 4000
`define FSC_PER8_US 8000
`define FSC_THR_STEP_MV 10'h01E
`define FSC_DW 12
`define FSC_TW 19
`define FSC_NFAULT 4
`define FSC_BATT_IDX 0
`endif

// *** logic/fsc_debounce.sv ***
// One fault debounce counter, advanced once per completed scan.
// Assumes scan_done_in is a one-cycle pulse on clock_in.
module fsc_debounce
  import fsc_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  // Scan result
  input wire logic scan_done_in,
  input wire logic fault_raw_in,
  // Count selection
  input wire logic bypass_in,
  input wire logic [4:0] target_in,
  // Debounced flag
  output logic fault_flag_out
);
  fsc_dbn_state_t s_q;
  fsc_dbn_state_t s_d;
  logic [4:0] inc;

  always_comb begin
    s_d = s_q;
    inc = s_q.count + 5'h01;
    if (scan_done_in) begin
      if (!fault_raw_in) begin
        s_d.count = '0; // RQ14
        s_d.flag = 1'b0;
      end else if (bypass_in) begin
        s_d.flag = 1'b1; // RQ5
      end else if (inc >= target_in) begin
        s_d.count = target_in; // RQ14
        s_d.flag = 1'b1;
      end else begin
        s_d.count = inc;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

  assign fault_flag_out = s_q.flag;

  a_clear_on_clean: // RQ14
  assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && scan_done_in && !fault_raw_in |=> !fault_flag_out)
    else $error("fault flag not cleared by clean scan");

  a_bypass_direct: // RQ5
  assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && scan_done_in && bypass_in
      |=> fault_flag_out == $past(fault_raw_in))
    else $error("undebounced flag does not follow scan");

  a_rise_needs_count: // RQ14
  assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(fault_flag_out) && !$past(bypass_in)
      |-> $past(s_q.count) + 5'h01 >= $past(target_in))
    else $error("fault flagged before count reached");
endmodule

// *** logic/fsc_pkg.sv ***
// Types shared by the fault scan control modules.
// Assumes fsc_cfg.svh is on the include path.
`include "fsc_cfg.svh"
package fsc_pkg;
  typedef enum logic [1:0] {
    FSC_REP_CONT = 2'b00, FSC_REP_1MS = 2'b01,
    FSC_REP_4MS = 2'b10, FSC_REP_8MS = 2'b11
  } fsc_rep_t;
  typedef enum logic [1:0] {
    FSC_DBN_16 = 2'b00, FSC_DBN_8 = 2'b01,
    FSC_DBN_4 = 2'b10, FSC_DBN_NONE = 2'b11
  } fsc_dbn_t;
  typedef enum logic [1:0] {
    FSC_AVG_OFF = 2'b00, FSC_AVG_HALF = 2'b01,
    FSC_AVG_QTR = 2'b10, FSC_AVG_RSV = 2'b11
  } fsc_avg_t;
  typedef enum logic {FSC_ST_IDLE = 1'b0, FSC_ST_SCAN = 1'b1} fsc_state_t;
  typedef struct packed {
    logic [4:0] count;
    logic flag;
  } fsc_dbn_state_t;
  typedef struct packed {
    logic [7:0] timing;
    logic [7:0] avg_cfg;
    logic [7:0] rdata;
    fsc_state_t state;
    logic pending;
    logic [`FSC_TW-1:0] timer;
    logic start;
    logic [3:0] pins;
    logic sync1;
    logic sync2;
    logic [9:0] thr;
    logic dbl;
    logic [`FSC_DW-1:0] avg_pin;
    logic [`FSC_DW-1:0] avg_load;
    logic [`FSC_DW-1:0] avg_temp;
  } fsc_top_state_t;
endpackage

// *** logic/fsc_top.sv ***
// Input fault scan control: scan timing, debounce, threshold scale, averaging.
// Assumes a same-clock register port and analog scanner; the battery
// comparator level is asynchronous.
//
// Overview of operation
// RQ1: Repeat code 0 scans back to back.
// RQ2: Codes 1,2,3 start scans each 1/4/8 ms.
// RQ3: Software keeps timing reserved bits at 11.
// RQ4: Debounce select gives 16, 8, 4 counts.
// RQ5: Debounce select 3 reports faults undebounced.
// RQ6: Low-battery battery short uses own debounce bit.
// RQ7: Scale bit doubles every detection threshold.
// RQ8: Averaging 0 off, 1 equal halves.
// RQ9: Averaging 2 weights old 0.75, new 0.25.
// RQ10: Bit 5 bypasses averaging for bias load.
// RQ11: Bit 4 bypasses averaging for over-temperature.
// RQ12: Only enabled channels' pins are scanned.
// RQ13: Terminal short threshold steps 30 mV, rescaled.
// RQ14: Fault needs consecutive faulty scans; clean restarts.
// RQ15: Software avoids code 3; low bits zero.
`include "fsc_cfg.svh"
module fsc_top
  import fsc_pkg::*;
#(
  parameter int PER1_CYC = `FSC_PER1_US * `FSC_CLK_MHZ,
  parameter int PER4_CYC = `FSC_PER4_US * `FSC_CLK_MHZ,
  parameter int PER8_CYC = `FSC_PER8_US * `FSC_CLK_MHZ
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Channel selection and threshold code
  input wire logic chan1_scan_enable_in,
  input wire logic chan2_scan_enable_in,
  input wire logic [3:0] terminal_short_threshold_in,
  // Analog scanner
  input wire logic scan_done_in,
  input wire logic [`FSC_NFAULT-1:0] fault_raw_in,
  input wire logic battery_below_bias_in,
  input wire logic [`FSC_DW-1:0] meas_pin_in,
  input wire logic [`FSC_DW-1:0] meas_bias_load_in,
  input wire logic [`FSC_DW-1:0] meas_temp_in,
  // Scan control
  output logic scan_start_out,
  output logic scan_busy_out,
  output logic [3:0] scan_pins_out,
  // Results
  output logic [`FSC_NFAULT-1:0] fault_flag_out,
  output logic [9:0] threshold_mv_out,
  output logic threshold_double_out,
  output logic [`FSC_DW-1:0] avg_pin_out,
  output logic [`FSC_DW-1:0] avg_bias_load_out,
  output logic [`FSC_DW-1:0] avg_temp_out
);
  fsc_top_state_t s_q;
  fsc_top_state_t s_d;
  fsc_rep_t rep;
  fsc_dbn_t dbn;
  fsc_avg_t avg_mode;
  logic [`FSC_TW-1:0] per_last;
  logic tick;
  logic any_en;
  logic go;
  logic [4:0] gen_tgt;
  logic gen_byp;
  logic [4:0] tgt [`FSC_NFAULT];
  logic [`FSC_NFAULT-1:0] byp;
  logic [9:0] thr_base;
  logic [3:0] pin_sel;

  assign rep = fsc_rep_t'(s_q.timing[`FSC_REP_MSB:`FSC_REP_LSB]);
  assign dbn = fsc_dbn_t'(s_q.timing[`FSC_DBN_MSB:`FSC_DBN_LSB]);
  assign avg_mode = fsc_avg_t'(s_q.avg_cfg[`FSC_AVG_MSB:`FSC_AVG_LSB]);
  assign any_en = chan1_scan_enable_in | chan2_scan_enable_in;
  assign pin_sel = {{2{chan1_scan_enable_in}},
    {2{chan2_scan_enable_in}}}; // RQ12
  assign thr_base = 10'(terminal_short_threshold_in * `FSC_THR_STEP_MV);

  function automatic logic [`FSC_DW-1:0] avg_next(
    input fsc_avg_t m, input logic bypass,
    input logic [`FSC_DW-1:0] old, input logic [`FSC_DW-1:0] nw);
    logic [`FSC_DW+1:0] s;
    s = '0;
    avg_next = nw;
    if (!bypass && m == FSC_AVG_HALF) begin
      s = (`FSC_DW+2)'(old) + (`FSC_DW+2)'(nw); // RQ8
      avg_next = s[`FSC_DW:1];
    end else if (!bypass && m == FSC_AVG_QTR) begin
      s = ((`FSC_DW+2)'(old) << 1) + (`FSC_DW+2)'(old)
        + (`FSC_DW+2)'(nw); // RQ9
      avg_next = s[`FSC_DW+1:2];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Debounce selection
  always_comb begin
    gen_byp = 1'b0;
    case (dbn) // RQ4
      FSC_DBN_16: gen_tgt = `FSC_CNT16;
      FSC_DBN_8: gen_tgt = `FSC_CNT8;
      FSC_DBN_4: gen_tgt = `FSC_CNT4;
      default: begin
        gen_tgt = `FSC_CNT4;
        gen_byp = 1'b1; // RQ5
      end
    endcase
    for (int i = 0; i < `FSC_NFAULT; i++) begin
      tgt[i] = gen_tgt;
      byp[i] = gen_byp;
    end
    if (s_q.sync2) begin
      byp[`FSC_BATT_IDX] = 1'b0; // RQ6
      tgt[`FSC_BATT_IDX] = s_q.timing[`FSC_VSH_BIT] ? `FSC_CNT8 : `FSC_CNT16;
    end
  end

  generate
    for (genvar g = 0; g < `FSC_NFAULT; g++) begin : g_dbn
      fsc_debounce u_dbn (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .clk_en_in(clk_en_in),
        .scan_done_in(scan_done_in),
        .fault_raw_in(fault_raw_in[g]),
        .bypass_in(byp[g]),
        .target_in(tgt[g]),
        .fault_flag_out(fault_flag_out[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Repetition timer and scan sequencing
  always_comb begin
    case (rep) // RQ2
      FSC_REP_4MS: per_last = `FSC_TW'(PER4_CYC - 1);
      FSC_REP_8MS: per_last = `FSC_TW'(PER8_CYC - 1);
      default: per_last = `FSC_TW'(PER1_CYC - 1);
    endcase
    tick = (rep != FSC_REP_CONT) && (s_q.timer >= per_last);
    go = any_en && (rep == FSC_REP_CONT || tick || s_q.pending); // RQ1
  end

  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.sync1 = battery_below_bias_in;
    s_d.sync2 = s_q.sync1;
    s_d.dbl = s_q.timing[`FSC_DBL_BIT];
    s_d.thr = s_q.timing[`FSC_DBL_BIT] ? {thr_base[8:0], 1'b0}
      : thr_base; // RQ7 RQ13
    if (rep == FSC_REP_CONT || tick) begin
      s_d.timer = '0; // RQ2
    end else begin
      s_d.timer = s_q.timer + `FSC_TW'(1);
    end
    case (s_q.state)
      FSC_ST_IDLE: begin
        if (go) begin
          s_d.state = FSC_ST_SCAN;
          s_d.start = 1'b1;
          s_d.pending = 1'b0;
          s_d.pins = pin_sel; // RQ12
        end
      end
      FSC_ST_SCAN: begin
        if (scan_done_in) begin
          if (go) begin
            s_d.start = 1'b1; // RQ1
            s_d.pending = 1'b0;
            s_d.pins = pin_sel; // RQ12
          end else begin
            s_d.state = FSC_ST_IDLE;
          end
        end else if (tick) begin
          s_d.pending = 1'b1;
        end
      end
      default: s_d.state = FSC_ST_IDLE;
    endcase
    if (scan_done_in) begin
      s_d.avg_pin = avg_next(avg_mode, 1'b0, s_q.avg_pin, meas_pin_in);
      s_d.avg_load = avg_next(avg_mode, s_q.avg_cfg[`FSC_BLB_BIT],
        s_q.avg_load, meas_bias_load_in); // RQ10
      s_d.avg_temp = avg_next(avg_mode, s_q.avg_cfg[`FSC_OTB_BIT],
        s_q.avg_temp, meas_temp_in); // RQ11
    end
    if (reg_wr_in) begin
      case (reg_addr_in)
        `FSC_ADDR_TIMING: begin
          s_d.timing = reg_wdata_in;
          s_d.timer = '0;
        end
        `FSC_ADDR_AVG: s_d.avg_cfg = reg_wdata_in & `FSC_AVG_WMASK; // RQ15
        default: ;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        `FSC_ADDR_TIMING: s_d.rdata = s_q.timing;
        `FSC_ADDR_AVG: s_d.rdata = s_q.avg_cfg;
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
      s_q.timing <= `FSC_RST_TIMING;
      s_q.avg_cfg <= `FSC_RST_AVG;
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out = s_q.rdata;
  assign scan_start_out = s_q.start;
  assign scan_busy_out = s_q.state == FSC_ST_SCAN;
  assign scan_pins_out = s_q.pins;
  assign threshold_mv_out = s_q.thr;
  assign threshold_double_out = s_q.dbl;
  assign avg_pin_out = s_q.avg_pin;
  assign avg_bias_load_out = s_q.avg_load;
  assign avg_temp_out = s_q.avg_temp;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_back_to_back: // RQ1
  assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && scan_busy_out && scan_done_in && rep == FSC_REP_CONT
      && any_en |=> scan_start_out && scan_busy_out)
    else $error("continuous mode left a gap between scans");

  a_period_wrap: // RQ2
  assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && !reg_wr_in && rep == FSC_REP_4MS
      && s_q.timer == `FSC_TW'(PER4_CYC - 1) |=> s_q.timer == '0)
    else $error("repetition timer did not wrap at period");

  a_start_enabled: // RQ12
  assert property (@(posedge clock_in) disable iff (!rstn_in)
    scan_start_out |-> scan_pins_out != 4'h0
      && scan_pins_out[3] == scan_pins_out[2])
    else $error("scan started with no enabled channel");

  a_batt_target: // RQ6
  assert property (@(posedge clock_in) disable iff (!rstn_in)
    s_q.sync2 |-> !byp[`FSC_BATT_IDX] && tgt[`FSC_BATT_IDX] ==
      (s_q.timing[`FSC_VSH_BIT] ? `FSC_CNT8 : `FSC_CNT16))
    else $error("battery short debounce count wrong");

  a_thr_scale: // RQ7
  assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in |=> threshold_mv_out ==
      ($past(s_q.timing[`FSC_DBL_BIT]) ? $past(thr_base) << 1
        : $past(thr_base)))
    else $error("threshold scaling mismatch");

  a_avg_half: // RQ8
  assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && scan_done_in && avg_mode == FSC_AVG_HALF |=>
      avg_pin_out == `FSC_DW'(((`FSC_DW+1)'($past(avg_pin_out))
        + (`FSC_DW+1)'($past(meas_pin_in))) >> 1))
    else $error("half weight average wrong");

  a_avg_quarter: // RQ9
  assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && scan_done_in && avg_mode == FSC_AVG_QTR |=>
      avg_pin_out == `FSC_DW'((3 * (`FSC_DW+2)'($past(avg_pin_out))
        + (`FSC_DW+2)'($past(meas_pin_in))) >> 2))
    else $error("quarter weight average wrong");

  a_load_bypass: // RQ10
  assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && scan_done_in && s_q.avg_cfg[`FSC_BLB_BIT] |=>
      avg_bias_load_out == $past(meas_bias_load_in))
    else $error("bias load averaging not bypassed");

  a_temp_bypass: // RQ11
  assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && scan_done_in && s_q.avg_cfg[`FSC_OTB_BIT] |=>
      avg_temp_out == $past(meas_temp_in))
    else $error("temperature averaging not bypassed");

  a_avg_low_zero: // RQ15
  assert property (@(posedge clock_in) disable iff (!rstn_in)
    clk_en_in && reg_rd_in && reg_addr_in == `FSC_ADDR_AVG |=>
      reg_rdata_out[`FSC_AVG_RSV_MSB:`FSC_AVG_RSV_LSB] == 4'h0)
    else $error("averaging register low bits not zero");
endmodule

// *** sim/fsc_scan_model.sv ***
// Behavioural analog scanner answering each scan start with a done pulse.
// Assumes scan_start_out is a one-cycle pulse; drives on the falling edge.
module fsc_scan_model #(
  parameter int LAT = 4
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Scan request and data to report
  input wire logic start_in,
  input wire logic [3:0] fault_in,
  input wire logic [11:0] pin_in,
  input wire logic [11:0] load_in,
  input wire logic [11:0] temp_in,
  // Scan result
  output logic done_out,
  output logic [3:0] fault_out,
  output logic [11:0] pin_out,
  output logic [11:0] load_out,
  output logic [11:0] temp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always @(negedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt <= 0;
      done_out <= 1'b0;
    end else begin
      done_out <= (cnt == 1);
      if (start_in) cnt <= LAT;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
  // Results are only valid with done; otherwise show the inverse
  assign fault_out = done_out ? fault_in : ~fault_in;
  assign pin_out = done_out ? pin_in : ~pin_in;
  assign load_out = done_out ? load_in : ~load_in;
  assign temp_out = done_out ? temp_in : ~temp_in;
endmodule

// *** sim/tb_fsc_top.sv ***
// Bench for the fault scan control block: registers, scan timing,
// debounce, threshold scale and averaging.
// Assumes shortened repetition periods and the behavioural scanner.
module tb_fsc_top import fsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAT = 4;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, c1 = 0, c2 = 0, bb = 0, ce = 1;
  logic start, busy, done, dbl;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdat, acfg = 8'h00;
  logic [7:0] lf = 8'h25, lm = 8'h25;
  logic [3:0] ts = 4'h0, fr = 4'h0, fro, flag, pins;
  logic [11:0] mp = 12'h000, ml = 12'h000, mt = 12'h000, mpo, mlo, mto;
  logic [11:0] ap, al, at, op = 12'h000, ol = 12'h000, ot = 12'h000;
  logic [9:0] thr;
  logic [35:0] q[$];
  int num_errors = 0, checks_done = 0, cyc = 0;

  initial forever #12.5 clk = ~clk;

  fsc_top #(.PER1_CYC(20), .PER4_CYC(80), .PER8_CYC(160)) fsc_top_i (
    .clock_in(clk), .rstn_in(rstn), .clk_en_in(ce),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdat), .chan1_scan_enable_in(c1),
    .chan2_scan_enable_in(c2), .terminal_short_threshold_in(ts),
    .scan_done_in(done), .fault_raw_in(fro), .battery_below_bias_in(bb),
    .meas_pin_in(mpo), .meas_bias_load_in(mlo), .meas_temp_in(mto),
    .scan_start_out(start), .scan_busy_out(busy), .scan_pins_out(pins),
    .fault_flag_out(flag), .threshold_mv_out(thr),
    .threshold_double_out(dbl), .avg_pin_out(ap),
    .avg_bias_load_out(al), .avg_temp_out(at));
  fsc_scan_model #(.LAT(LAT)) fsc_scan_model_i (.clock_in(clk),
    .rstn_in(rstn), .start_in(start), .fault_in(fr), .pin_in(mp),
    .load_in(ml), .temp_in(mt), .done_out(done), .fault_out(fro),
    .pin_out(mpo), .load_out(mlo), .temp_out(mto));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] nxt(input logic [7:0] s);
    nxt = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [11:0] av(input logic [1:0] m, input logic b,
      input logic [11:0] o, n);
    logic [13:0] s;
    s = (m == 2'h2) ? 14'(o) * 14'h0003 + 14'(n) : 14'(o) + 14'(n);
    if (b || m == 2'h0 || m == 2'h3) av = n;
    else av = (m == 2'h1) ? 12'(s >> 1) : 12'(s >> 2);
  endfunction
  task automatic chk(input string n, input logic [11:0] e, g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    if (a == 8'h68) acfg = d & 8'hF0;
  endtask
  task automatic rreg(input logic [7:0] a, e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 0;
    @(negedge clk);
    chk("rdata", 12'(e), 12'(rdat));
  endtask
  // Waits for one scan with the given faults and lets its flags settle
  task automatic sc(input logic [3:0] f);
    fr = f;
    @(posedge clk iff done === 1'b1);
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic dbn(input logic [7:0] t, input int b, n);
    int k;
    wreg(8'h67, t);
    sc(4'h0);
    for (k = 1; k < n; k++) sc(4'h1 << b);
    sc(4'h0);
    k = 0;
    do begin
      sc(4'h1 << b);
      k++;
    end while (flag[b] !== 1'b1 && k < 20);
    chk("debounce", 12'(n), 12'(k));
    sc(4'h0);
    chk("flag_clear", 12'h000, 12'(flag[b]));
  endtask
  task automatic per(input logic [7:0] t, input int e, input logic [3:0] p);
    int k;
    wreg(8'h67, t);
    repeat (2) @(negedge clk iff start === 1'b1);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (start !== 1'b1 && k < 400);
    chk("pins", 12'(p), 12'(pins));
    chk("busy", 12'h001, 12'(busy));
    chk("period", 12'(e), 12'(k));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Expected averages noted at each completed scan, new data after it
  always @(posedge clk) if (rstn && done === 1'b1) begin
    op = av(acfg[7:6], 1'b0, op, mpo);
    ol = av(acfg[7:6], acfg[5], ol, mlo);
    ot = av(acfg[7:6], acfg[4], ot, mto);
    q.push_back({op, ol, ot});
  end
  always @(negedge clk) if (done === 1'b1) begin
    lm = nxt(lm);
    mp = {lm, lm[7:4]};
    lm = nxt(lm);
    ml = {lm[3:0], lm};
    lm = nxt(lm);
    mt = {lm, lm[3:0]};
  end
  always @(posedge clk) if (rstn && done === 1'b1) begin
    logic [35:0] e;
    @(posedge clk);
    @(negedge clk);
    e = (q.size() > 0) ? q.pop_front() : ~{ap, al, at};
    chk("avg_pin", e[35:24], ap);
    chk("avg_load", e[23:12], al);
    chk("avg_temp", e[11:0], at);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("BAD timeout expected 0 seen %0d", cyc);
      report_and_stop;
    end
  end

  initial begin
    int i;
    int k;
    repeat (10) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    rreg(8'h67, 8'hB8);
    rreg(8'h68, 8'h00);
    rreg(8'h69, 8'h00);
    wreg(8'h68, 8'h7F);
    rreg(8'h68, 8'h70);
    wreg(8'h68, 8'h00);
    $display("test registers done");
    c1 = 1'b1;
    per(8'h78, 20, 4'hC);
    c1 = 1'b0;
    c2 = 1'b1;
    per(8'hB8, 80, 4'h3);
    c1 = 1'b1;
    per(8'hF8, 160, 4'hF);
    c2 = 1'b0;
    per(8'h38, LAT + 1, 4'hC);
    rreg(8'h67, 8'h38);
    wreg(8'h67, 8'h78);
    c1 = 1'b0;
    repeat (30) @(negedge clk);
    k = 0;
    repeat (60) @(negedge clk) if (start !== 1'b0) k++;
    chk("idle_starts", 12'h000, 12'(k));
    chk("idle_busy", 12'h000, 12'(busy));
    // A write while the clock enable is low must not land
    ce = 1'b0;
    wreg(8'h67, 8'h38);
    ce = 1'b1;
    rreg(8'h67, 8'h78);
    c1 = 1'b1;
    $display("test scan timing done");
    for (i = 0; i < 8; i++) begin
      lf = nxt(lf);
      ts = lf[3:0];
      wreg(8'h67, 8'h38 | 8'(i & 1));
      repeat (2) @(negedge clk);
      k = (12'h01E * ts) << (i & 1);
      chk("threshold", 12'(k), 12'(thr));
      chk("double", 12'(i & 1), 12'(dbl));
    end
    $display("test threshold done");
    for (i = 0; i < 4; i++) begin
      dbn(8'h30 | 8'(i << 2), 1, i == 3 ? 1 : 16 >> i);
    end
    dbn(8'h38, 0, 4);
    bb = 1'b1;
    dbn(8'h3C, 0, 16);
    dbn(8'h3E, 0, 8);
    bb = 1'b0;
    $display("test debounce done");
    for (i = 0; i < 8; i++) begin
      @(posedge clk iff done === 1'b1);
      // Reserved averaging code 3 is never programmed
      wreg(8'h68, {2'(i % 3), 2'(i >> 1), 4'h0});
      repeat (3) sc(4'h0);
    end
    $display("test averaging done");
    report_and_stop;
  end
endmodule
